// >>> core/gain_monitor_map.vh
// constants for the pi gain readback and monitor channel register bank
// Behaviour
// (RL1) current integral gain in use in 31-16
// (RL2) current proportional gain in use in 15-0
// (RL3) speed integral gain in use in 31-16
// (RL4) speed proportional gain in use in 15-0
// (RL5) bits 11-0 hold monitored variable address
// (RL6) nonzero fraction n scales by n/8
// (RL7) fraction zero: enumerated value, max 31
// (RL8) power-of-two scale acts only when fraction zero
// (RL9) polarity one: unipolar, 0pu 0V, 1pu 3V
// (RL10) polarity zero: bipolar, 1.5V centred, reset default
// (RL11) reserved bits 31-21 read zero, ignore writes
// (RL12) use divide-by-eight, not sixteen; flagged
`ifndef GAIN_MONITOR_MAP_VH
`define GAIN_MONITOR_MAP_VH

// register indices as printed; byte address is four times the index
`define IDX_CUR_GAIN 10'h0F0
`define IDX_SPD_GAIN 10'h0F2
`define IDX_MON_CFG 10'h0F4

// field positions of the monitor configuration word and the gain readback words
`define PTR_MSB 11
`define PTR_LSB 0
`define POL_BIT 12
`define FRAC_MSB 16
`define FRAC_LSB 13
`define POW_MSB 20
`define POW_LSB 17
`define GAIN_HI_MSB 31
`define GAIN_HI_LSB 16
`define GAIN_LO_MSB 15
`define GAIN_LO_LSB 0

// reset values and writable mask
`define RST_MON_CFG 32'h00110000
`define RST_GAIN 32'h00000000
`define MON_WMASK 32'h001FFFFF

// dac mapping: one per-unit is 2^14 counts of the variable
`define DAC_UNI_SHIFT 2
`define DAC_BI_SHIFT 3
`define DAC_MID 23'sh00800
`define DAC_MAX 23'sh00FFF
`define ENUM_MAX 16'sh001F

// axi response codes
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define RESP_DECERR 2'h3

`endif

// >>> core/gain_monitor_regs.v
// axi4-lite register bank: pi gain readback and monitor channel one
//
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
`include "gain_monitor_map.vh"
module gain_monitor_regs
(
    input wire aclk,
    input wire aresetn,
    input wire [11:0] s_axi_awaddr,
    input wire [2:0] s_axi_awprot,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [11:0] s_axi_araddr,
    input wire [2:0] s_axi_arprot,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire [15:0] current_integral_gain_in_use,
    input wire [15:0] current_proportional_gain_in_use,
    input wire [15:0] speed_integral_gain_in_use,
    input wire [15:0] speed_proportional_gain_in_use,
    input wire signed [15:0] monitor_variable_value,
    output reg [11:0] monitor_variable_pointer,
    output reg [11:0] monitor_dac_code,
    output reg monitor_enum_mode
);
    // byte addresses derived from the printed indices
    localparam [11:0] ADDR_CUR = {`IDX_CUR_GAIN, 2'b00};
    localparam [11:0] ADDR_SPD = {`IDX_SPD_GAIN, 2'b00};
    localparam [11:0] ADDR_MON = {`IDX_MON_CFG, 2'b00};

    // captured write address and data
    reg aw_full_q;
    reg aw_full_d;
    reg [11:0] aw_addr_q;
    reg w_full_q;
    reg w_full_d;
    reg [31:0] w_data_q;
    reg [3:0] w_strb_q;
    reg bvalid_d;
    reg [1:0] bresp_d;
    reg do_write;

    // read side
    reg rvalid_d;
    reg ar_take;
    reg [31:0] rdata_d;
    reg [1:0] rresp_d;

    // register contents
    reg [31:0] cur_gain_q;
    reg [31:0] spd_gain_q;
    reg [31:0] mon_cfg_q;
    reg [31:0] mon_cfg_d;
    reg [31:0] lane_mask;

    // monitor datapath
    wire signed [21:0] scaled;
    wire enum_mode;
    wire [11:0] code;
    reg signed [15:0] var_q;

    // the readback words track the gains in use every cycle
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cur_gain_q <= `RST_GAIN;
            spd_gain_q <= `RST_GAIN;
        end
        else
        begin
            cur_gain_q[`GAIN_HI_MSB:`GAIN_HI_LSB] <=
                current_integral_gain_in_use; // RL1
            cur_gain_q[`GAIN_LO_MSB:`GAIN_LO_LSB] <=
                current_proportional_gain_in_use; // RL2
            spd_gain_q[`GAIN_HI_MSB:`GAIN_HI_LSB] <=
                speed_integral_gain_in_use; // RL3
            spd_gain_q[`GAIN_LO_MSB:`GAIN_LO_LSB] <=
                speed_proportional_gain_in_use; // RL4
        end
    end

    // write channel control; address and data may arrive in any order
    always @*
    begin
        do_write = aw_full_q && w_full_q && !s_axi_bvalid;
        if (aw_full_q)
            aw_full_d = !do_write;
        else
            aw_full_d = s_axi_awvalid && s_axi_awready;
        if (w_full_q)
            w_full_d = !do_write;
        else
            w_full_d = s_axi_wvalid && s_axi_wready;
        if (s_axi_bvalid)
            bvalid_d = !s_axi_bready;
        else
            bvalid_d = do_write;
    end

    // byte-lane merge for the only writable register
    always @*
    begin
        lane_mask = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}},
                     {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
        mon_cfg_d = mon_cfg_q;
        bresp_d = s_axi_bresp;
        if (do_write)
        begin
            case (aw_addr_q)
                ADDR_MON:
                begin
                    // reserved bits cannot be set by any write
                    mon_cfg_d = ((mon_cfg_q & ~lane_mask) |
                        (w_data_q & lane_mask)) & `MON_WMASK; // RL11
                    bresp_d = `RESP_OKAY;
                end
                ADDR_CUR, ADDR_SPD:
                    // readback words ignore writes and flag the error
                    bresp_d = `RESP_SLVERR;
                default:
                    bresp_d = `RESP_DECERR;
            endcase
        end
    end

    // write channel registers
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            aw_addr_q <= 12'h000;
            w_data_q <= 32'h00000000;
            w_strb_q <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RESP_OKAY;
            mon_cfg_q <= `RST_MON_CFG; // RL6 RL8 RL10
        end
        else
        begin
            aw_full_q <= aw_full_d;
            w_full_q <= w_full_d;
            if (s_axi_awvalid && s_axi_awready)
                aw_addr_q <= {s_axi_awaddr[11:2], 2'b00};
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            // ready drops while a beat is held or a response waits
            s_axi_awready <= !aw_full_d && !bvalid_d;
            s_axi_wready <= !w_full_d && !bvalid_d;
            s_axi_bvalid <= bvalid_d;
            s_axi_bresp <= bresp_d;
            mon_cfg_q <= mon_cfg_d; // RL5
        end
    end

    // read decode; the answer is registered with the address
    always @*
    begin
        ar_take = s_axi_arvalid && s_axi_arready;
        if (s_axi_rvalid)
            rvalid_d = !s_axi_rready;
        else
            rvalid_d = ar_take;
        rdata_d = s_axi_rdata;
        rresp_d = s_axi_rresp;
        if (ar_take)
        begin
            rresp_d = `RESP_OKAY;
            case ({s_axi_araddr[11:2], 2'b00})
                ADDR_CUR:
                    rdata_d = cur_gain_q; // RL1 RL2
                ADDR_SPD:
                    rdata_d = spd_gain_q; // RL3 RL4
                ADDR_MON:
                    rdata_d = mon_cfg_q & `MON_WMASK; // RL11
                default:
                begin
                    rdata_d = 32'h00000000;
                    rresp_d = `RESP_DECERR;
                end
            endcase
        end
    end

    // read channel registers
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `RESP_OKAY;
        end
        else
        begin
            // one read at a time; a new address waits for rready
            s_axi_arready <= !rvalid_d;
            s_axi_rvalid <= rvalid_d;
            s_axi_rdata <= rdata_d;
            s_axi_rresp <= rresp_d;
        end
    end

    // variable sampled once so the scaler sees a stable operand
    always @(posedge aclk)
    begin
        if (!aresetn)
            var_q <= 16'sh0000;
        else
            var_q <= monitor_variable_value;
    end

    monitor_scaler u_scaler
    (
        .value(var_q),
        .frac(mon_cfg_q[`FRAC_MSB:`FRAC_LSB]),
        .pow(mon_cfg_q[`POW_MSB:`POW_LSB]),
        .scaled(scaled),
        .enum_mode(enum_mode)
    );

    monitor_code_mapper u_mapper
    (
        .scaled(scaled),
        .unipolar(mon_cfg_q[`POL_BIT]),
        .code(code)
    );

    // monitor outputs; pointer leads the code by one cycle
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            monitor_variable_pointer <= 12'h000;
            monitor_dac_code <= 12'h000;
            monitor_enum_mode <= 1'b0;
        end
        else
        begin
            monitor_variable_pointer <=
                mon_cfg_d[`PTR_MSB:`PTR_LSB]; // RL5
            monitor_dac_code <= code; // RL9 RL10
            monitor_enum_mode <= enum_mode; // RL7
        end
    end
endmodule // gain_monitor_regs
`default_nettype wire

// >>> core/monitor_code_mapper.v
// maps a scaled per-unit value onto a 12-bit 0..3V dac code
`timescale 1ns/100ps
`default_nettype none
`include "gain_monitor_map.vh"
module monitor_code_mapper
(
    input wire signed [21:0] scaled,
    input wire unipolar,
    output reg [11:0] code
);
    wire signed [22:0] wide;
    reg signed [22:0] t;

    assign wide = {scaled[21], scaled};

    // saturate so an overscaled variable pins at a rail, not wraps
    always @*
    begin
        if (unipolar)
            t = wide >>> `DAC_UNI_SHIFT; // RL9
        else
            t = (wide >>> `DAC_BI_SHIFT) + `DAC_MID; // RL10
        if (t < 23'sh00000)
            code = 12'h000;
        else if (t > `DAC_MAX)
            code = 12'hFFF;
        else
            code = t[11:0];
    end
endmodule // monitor_code_mapper
`default_nettype wire

// >>> core/monitor_scaler.v
// scaling stage of the monitor channel: fraction or power-of-two
`timescale 1ns/100ps
`default_nettype none
`include "gain_monitor_map.vh"
module monitor_scaler
(
    input wire signed [15:0] value,
    input wire [3:0] frac,
    input wire [3:0] pow,
    output reg signed [21:0] scaled,
    output wire enum_mode
);
    wire signed [20:0] prod;
    wire [4:0] enum_val;
    wire [21:0] enum_shift;

    // fraction zero selects enumerated handling
    assign enum_mode = (frac == 4'h0); // RL7
    // 16x5 signed product cannot overflow 21 bits
    assign prod = value * $signed({1'b0, frac}); // RL6
    // enumerated values are limited to 0..31 before the shift
    assign enum_val = (value < 16'sh0000) ? 5'h00 :
        (value > `ENUM_MAX) ? 5'h1F : value[4:0]; // RL7
    assign enum_shift = {17'h0000, enum_val} << pow; // RL8

    // divide by eight, not sixteen, keeps unity gain at n = 8
    always @*
    begin
        if (enum_mode)
            scaled = $signed(enum_shift); // RL8
        else
            scaled = {{4{prod[20]}}, prod[20:3]}; // RL6 RL12
    end
endmodule // monitor_scaler
`default_nettype wire

// >>> tb/gain_monitor_regs_props.sv
// concurrent checks for the gain readback and monitor register bank
`timescale 1ns/100ps
`default_nettype none
module gain_monitor_regs_props
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [15:0] current_integral_gain_in_use,
    input wire logic [15:0] current_proportional_gain_in_use,
    input wire logic [15:0] speed_integral_gain_in_use,
    input wire logic [15:0] speed_proportional_gain_in_use,
    input wire logic [11:0] monitor_variable_pointer
);
    logic [11:0] wa_q;
    // keep the write address, the response comes cycles later
    always_ff @(posedge aclk)
    begin
        if (s_axi_awvalid && s_axi_awready)
            wa_q <= s_axi_awaddr;
    end
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_rd(a);
        s_axi_arvalid && s_axi_arready && s_axi_araddr == a;
    endsequence
    sequence s_wr;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    // gains reach the read word two edges after sampling
    property p_cur_rd;
        s_rd(12'h3C0) |=> s_axi_rdata == {$past(current_integral_gain_in_use,
            2), $past(current_proportional_gain_in_use, 2)};
    endproperty
    property p_spd_rd;
        s_rd(12'h3C8) |=> s_axi_rdata == {$past(speed_integral_gain_in_use,
            2), $past(speed_proportional_gain_in_use, 2)};
    endproperty
    property p_resv;
        s_rd(12'h3D0) |=> s_axi_rdata[31:21] == 11'h000;
    endproperty
    property p_ptr_upd;
        $changed(monitor_variable_pointer) |-> $rose(s_axi_bvalid);
    endproperty
    property p_ro;
        $rose(s_axi_bvalid) && (wa_q == 12'h3C0 || wa_q == 12'h3C8)
            |-> s_axi_bresp == 2'h2;
    endproperty
    property p_b_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    property p_r_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    property p_rd_lat;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    // bvalid is launched at the edge after both beats are held
    property p_wr_lat;
        s_wr |=> ##1 s_axi_bvalid;
    endproperty
    a_cur_rd: assert property (p_cur_rd) else $error("current gain word");
    a_spd_rd: assert property (p_spd_rd) else $error("speed gain word");
    a_resv: assert property (p_resv) else $error("reserved bits set");
    a_ptr_upd: assert property (p_ptr_upd) else $error("pointer moved");
    a_ro: assert property (p_ro) else $error("readback write accepted");
    a_b_hold: assert property (p_b_hold) else $error("bvalid dropped");
    a_r_hold: assert property (p_r_hold) else $error("rvalid dropped");
    a_rd_lat: assert property (p_rd_lat) else $error("read late");
    a_wr_lat: assert property (p_wr_lat) else $error("write late");
endmodule // gain_monitor_regs_props
bind gain_monitor_regs gain_monitor_regs_props i_props (.aclk, .aresetn,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
    .s_axi_rready, .current_integral_gain_in_use,
    .current_proportional_gain_in_use, .speed_integral_gain_in_use,
    .speed_proportional_gain_in_use, .monitor_variable_pointer);
`default_nettype wire

// >>> tb/gain_monitor_regs_test.sv
// self-checking bench for the gain readback and monitor register bank
`timescale 1ns/100ps
`default_nettype none
module gain_monitor_regs_test;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
    logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
    logic s_axi_arready, s_axi_rvalid, s_axi_rready, monitor_enum_mode;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [11:0] monitor_variable_pointer, monitor_dac_code;
    logic [2:0] s_axi_awprot, s_axi_arprot;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [15:0] current_integral_gain_in_use;
    logic [15:0] current_proportional_gain_in_use;
    logic [15:0] speed_integral_gain_in_use, speed_proportional_gain_in_use;
    logic signed [15:0] monitor_variable_value;
    int n_fail, compares;
    // config, variable and expected code; one per-unit is 16'h4000
    logic [31:0] cfg_t[9] = '{32'h00110000, 32'h00110000, 32'h00111000,
        32'h00109000, 32'h00041000, 32'h00001000, 32'h0011F000,
        32'h0011F000, 32'h00001000};
    logic [15:0] val_t[9] = '{16'h2000, 16'hC000, 16'h2000, 16'h2000,
        16'h0028, 16'h0028, 16'h2000, 16'h4000, 16'hFFF0};
    logic [11:0] code_t[9] = '{12'hC00, 12'h000, 12'h800, 12'h400,
        12'h01F, 12'h007, 12'hF00, 12'hFFF, 12'h000};

    gain_monitor_regs i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .current_integral_gain_in_use,
        .current_proportional_gain_in_use, .speed_integral_gain_in_use,
        .speed_proportional_gain_in_use, .monitor_variable_value,
        .monitor_variable_pointer, .monitor_dac_code, .monitor_enum_mode);

    task finish_test;
        if (n_fail == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e)
        begin
            $display("[FAIL] %0t got %h expected %h", $time, g, e);
            n_fail++;
        end
    endtask

    // a hung handshake is counted and ends the run
    task tmo(input int n);
        if (n >= 50)
        begin
            $display("[FAIL] %0t handshake timeout", $time);
            n_fail++;
            finish_test;
        end
    endtask

    // bready is raised only after bvalid, so the response hold is exercised
    task wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do
        begin
            @(posedge aclk);
            n++;
            if (s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'b0;
        end
        while (!s_axi_bvalid && n < 50);
        tmo(n);
        s_axi_bready <= 1'b1;
        @(posedge aclk);
        chk(s_axi_bresp, r);
        s_axi_bready <= 1'b0;
    endtask

    task rd(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do
        begin
            @(posedge aclk);
            n++;
            if (s_axi_arready)
                s_axi_arvalid <= 1'b0;
        end
        while (!s_axi_rvalid && n < 50);
        tmo(n);
        s_axi_rready <= 1'b1;
        @(posedge aclk);
        chk(s_axi_rdata, d);
        chk(s_axi_rresp, r);
        s_axi_rready <= 1'b0;
    endtask

    initial
    begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end

    initial
    begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
        {s_axi_arvalid, s_axi_rready, s_axi_awprot, s_axi_arprot} = 8'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 56'h0;
        s_axi_wstrb = 4'hF;
        current_integral_gain_in_use = 16'h1234;
        current_proportional_gain_in_use = 16'h0ABC;
        speed_integral_gain_in_use = 16'h5678;
        speed_proportional_gain_in_use = 16'h0DEF;
        monitor_variable_value = 16'h0000;
        n_fail = 0;
        compares = 0;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        rd(12'h3D0, 32'h00110000, 2'h0);
        rd(12'h3C0, 32'h12340ABC, 2'h0);
        rd(12'h3C8, 32'h56780DEF, 2'h0);
        wr(12'h3C8, 32'hFFFFFFFF, 2'h2);
        current_integral_gain_in_use <= 16'hFEDC;
        current_proportional_gain_in_use <= 16'h0321;
        wr(12'h3C0, 32'h00000000, 2'h2);
        rd(12'h3C0, 32'hFEDC0321, 2'h0);
        rd(12'h3C8, 32'h56780DEF, 2'h0);
        wr(12'h100, 32'h00000000, 2'h3);
        rd(12'h100, 32'h00000000, 2'h3);
        wr(12'h3D0, 32'hFFFFFFFF, 2'h0);
        rd(12'h3D0, 32'h001FFFFF, 2'h0);
        chk(monitor_variable_pointer, 32'h00000FFF);
        // only the low byte lane is written; upper bytes keep their value
        s_axi_wstrb <= 4'h1;
        wr(12'h3D0, 32'h00000000, 2'h0);
        s_axi_wstrb <= 4'hF;
        rd(12'h3D0, 32'h001FFF00, 2'h0);
        chk(monitor_variable_pointer, 32'h00000F00);
        // each table row rewrites the config, pointer field left zero
        for (int i = 0; i < 9; i++)
        begin
            wr(12'h3D0, cfg_t[i], 2'h0);
            monitor_variable_value <= val_t[i];
            repeat (4) @(posedge aclk);
            chk(monitor_dac_code, code_t[i]);
            chk(monitor_enum_mode, cfg_t[i][16:13] == 4'h0);
        end
        finish_test;
    end
endmodule // gain_monitor_regs_test
`default_nettype wire
